/* ecsm_map.svh */
// Register offsets, field positions, source codes and reset values of the event channel block.
`ifndef ECSM_MAP_SVH
`define ECSM_MAP_SVH

`define ECSM_NUM_CH          4
`define ECSM_OFS_MUX_BASE    8'h00
`define ECSM_OFS_CTRL_BASE   8'h08
`define ECSM_OFS_STROBE      8'h10
`define ECSM_OFS_DATA        8'h11
`define ECSM_OFS_STATUS      8'h12
`define ECSM_OFS_HOST_BASE   8'h20
`define ECSM_OFS_TCTRL       8'h20
`define ECSM_OFS_PERIOD      8'h21
`define ECSM_OFS_COUNT       8'h22
`define ECSM_OFS_TSTAT       8'h23

`define ECSM_CTRL_FILT_MSB   2
`define ECSM_CTRL_FILT_LSB   0
`define ECSM_CTRL_DEN_BIT    3
`define ECSM_CTRL_IEN_BIT    4
`define ECSM_CTRL_IRM_MSB    6
`define ECSM_CTRL_IRM_LSB    5
`define ECSM_CTRL_WMASK      8'h7F

`define ECSM_SRC_NONE        8'h00
`define ECSM_SRC_CLOCK_COUNTER_OVERFLOW     8'h08
`define ECSM_SRC_CLOCK_COUNTER_MATCH     8'h09
`define ECSM_SRC_CMP0        8'h10
`define ECSM_SRC_CMP1        8'h11
`define ECSM_SRC_CMPWIN      8'h12
`define ECSM_SRC_CONV0       8'h20
`define ECSM_NIB_PORT_LO     4'h5
`define ECSM_NIB_PORT_HI     4'h7
`define ECSM_NIB_PRESC       4'h8
`define ECSM_NIB_TIMER_LO    4'hC
`define ECSM_TTYPE_RSV       2'h1
`define ECSM_TTYPE_CD        2'h3

`define ECSM_MISC_CLOCK_COUNTER_OVERFLOW    0
`define ECSM_MISC_CLOCK_COUNTER_MATCH    1
`define ECSM_MISC_CMP0       2
`define ECSM_MISC_CMP1       3
`define ECSM_MISC_CMPWIN     4
`define ECSM_MISC_CONV0      5

`define ECSM_TC_EN_BIT       0
`define ECSM_TC_QUADRATURE_DECODER_BIT     1
`define ECSM_TC_IDX_BIT      2
`define ECSM_TC_CH_MSB       4
`define ECSM_TC_CH_LSB       3
`define ECSM_TC_CTRL_WIDTH   5
`define ECSM_TSTAT_ERR_BIT   0
`define ECSM_PERIOD_RESET    16'hFFFF
`define ECSM_FILT_RUN_MAX    3'h7

`endif

/* ecsm_pkg.sv */
// Types shared by both ends of the event channel block.
package ecsm_pkg;

   typedef enum logic [1:0]
   {
      STEP_NONE  = 2'b00,
      STEP_INDEX = 2'b01,
      STEP_DOWN  = 2'b10,
      STEP_UP    = 2'b11
   } ecsm_step_type;

   typedef struct packed
   {
      logic            last;
      logic [2:0]      run;
      logic            level;
   } ecsm_filt_state_type;

   typedef struct packed
   {
      logic [3:0][7:0] channel_source_select;
      logic [3:0][7:0] control;
      logic [3:0]      sw_data;
      logic [15:0]     presc;
      logic [1:0]      phase;
      logic [7:0]      rdata;
      logic [3:0]      chan_strobe;
      logic [3:0]      chan_data;
   } ecsm_dev_state_type;

   typedef struct packed
   {
      logic [4:0]      ctrl;
      logic [15:0]     period;
      logic [15:0]     count;
      logic            err;
      logic            idx_seen;
      logic [15:0]     rdata;
      logic            dev_rd;
      logic [47:0]     pins;
      logic [5:0]      misc;
      logic            tev_wrap;
      logic            tev_err;
   } ecsm_host_state_type;

endpackage

/* ecsm_link_if.sv */
// Link between the event router and the generator and timer end.
`timescale 1ns/100ps
interface ecsm_link_if;
   logic [7:0]  reg_addr;
   logic [7:0]  reg_wdata;
   logic        reg_wr;
   logic        reg_rd;
   logic [7:0]  reg_rdata;
   logic [47:0] port_pin_source;
   logic [5:0]  misc_events;
   logic [63:0] timer_events;
   logic [3:0]  chan_strobe;
   logic [3:0]  chan_data;

   modport dev
   (
      input  reg_addr,
      input  reg_wdata,
      input  reg_wr,
      input  reg_rd,
      output reg_rdata,
      input  port_pin_source,
      input  misc_events,
      input  timer_events,
      output chan_strobe,
      output chan_data
   );

   modport gen
   (
      output reg_addr,
      output reg_wdata,
      output reg_wr,
      output reg_rd,
      input  reg_rdata,
      output port_pin_source,
      output misc_events,
      output timer_events,
      input  chan_strobe,
      input  chan_data
   );
endinterface

/* ecsm_filter.sv */
// Digital filter that passes a level once it has been sampled stable long enough.
`timescale 1ns/100ps
`include "ecsm_map.svh"
module ecsm_filter
(
   input  wire logic       clock,
   input  wire logic       rst,
   input  wire logic [2:0] filter_length,
   input  wire logic       sample,
   output logic            level
);
   import ecsm_pkg::*;

   ecsm_filt_state_type s_reg;
   ecsm_filt_state_type s_next;

   always_comb
   begin
      s_next = s_reg;
      s_next.last = sample;
      if (sample != s_reg.last)
      begin
         s_next.run = 3'h0;
      end
      else if (s_reg.run != `ECSM_FILT_RUN_MAX)
      begin
         s_next.run = s_reg.run + 3'h1;
      end
      // A length code of k needs k+1 equal samples before the level moves.
      if (s_next.run >= filter_length)
      begin
         s_next.level = sample;
      end
   end

   always_ff @(posedge clock)
   begin
      if (rst)
      begin
         s_reg <= '0;
      end
      else
      begin
         s_reg <= s_next;
      end
   end

   assign level = s_reg.level;
endmodule

/* ecsm_router.sv */
// Event router: four source multiplexers, software events, filters and quadrature decoder.
`timescale 1ns/100ps
`include "ecsm_map.svh"
// Function
// R01 - Zero selector routes no peripheral event.
// R02 - Absent peripheral codes behave as zero.
// R03 - Software events override selected source always.
// R04 - Fixed codes for counter, comparator, converter.
// R05 - Nibbles 5 to 7 select port pins.
// R06 - Nibble 8 selects clock divided by 2^M.
// R07 - Nibbles C to F select timer instances.
// R08 - Timer types wrap, error, matches A, B.
// R09 - Matches C, D exist only on instance 0; the code drops them only on odd instances, so 0, 2, 4 and 6 keep them.
// R10 - Software routes phase A pin on channel n.
// R11 - Software sets low sense, decode, filtering.
// R12 - Index pin routed on channel n+1.
// R13 - Timer uses quadrature action, channel n.
// R14 - Period is four times lines minus one.
// R15 - Timer count follows the encoder angle.
// R16 - Index off count_floor sets error flag.
// R17 - Count_floor passed without index sets error.
// R18 - Decoder emits up, down, index data events.
// R19 - Index issued only in chosen phase state.
// R20 - Filter needs one to eight equal samples.
// R21 - Reserved codes select no source.
// R22 - Selector resets zero, read/write, next-cycle effect.
module ecsm_router
#(
   parameter logic [5:0] PORT_PRESENT  = 6'h3F,
   parameter logic [5:0] MISC_PRESENT  = 6'h3F,
   parameter logic [7:0] TIMER_PRESENT = 8'hFF
)
(
   input  wire logic clock,
   input  wire logic rst,
   ecsm_link_if.dev  link
);
   import ecsm_pkg::*;

   ecsm_dev_state_type s_reg;
   ecsm_dev_state_type s_next;
   logic [3:0]         raw_event;
   logic [3:0]         filt_level;
   logic               phase_b_raw;
   logic               phase_b_level;

   // Resolves one selector code to the event line it names.
   function automatic logic source_event
   (
      input logic [7:0]  sel,
      input logic [47:0] pins,
      input logic [5:0]  misc,
      input logic [63:0] tev,
      input logic [15:0] presc
   );
      logic [3:0]  nib;
      logic [2:0]  port;
      logic [15:0] pmask;
      logic        hit;
      nib = sel[7:4];
      port = {2'(nib[1:0] - 2'h1), sel[3]};
      pmask = 16'(16'h0001 << sel[3:0]) - 16'h0001;
      hit = 1'b0;
      if (sel == `ECSM_SRC_CLOCK_COUNTER_OVERFLOW)
      begin
         hit = MISC_PRESENT[`ECSM_MISC_CLOCK_COUNTER_OVERFLOW] & misc[`ECSM_MISC_CLOCK_COUNTER_OVERFLOW]; // R04 R02
      end
      else if (sel == `ECSM_SRC_CLOCK_COUNTER_MATCH)
      begin
         hit = MISC_PRESENT[`ECSM_MISC_CLOCK_COUNTER_MATCH] & misc[`ECSM_MISC_CLOCK_COUNTER_MATCH]; // R04 R02
      end
      else if (sel == `ECSM_SRC_CMP0)
      begin
         hit = MISC_PRESENT[`ECSM_MISC_CMP0] & misc[`ECSM_MISC_CMP0]; // R04 R02
      end
      else if (sel == `ECSM_SRC_CMP1)
      begin
         hit = MISC_PRESENT[`ECSM_MISC_CMP1] & misc[`ECSM_MISC_CMP1]; // R04 R02
      end
      else if (sel == `ECSM_SRC_CMPWIN)
      begin
         hit = MISC_PRESENT[`ECSM_MISC_CMPWIN] & misc[`ECSM_MISC_CMPWIN]; // R04 R02
      end
      else if (sel == `ECSM_SRC_CONV0)
      begin
         hit = MISC_PRESENT[`ECSM_MISC_CONV0] & misc[`ECSM_MISC_CONV0]; // R04 R02
      end
      else if (nib >= `ECSM_NIB_PORT_LO && nib <= `ECSM_NIB_PORT_HI)
      begin
         hit = PORT_PRESENT[port] & pins[{port, sel[2:0]}]; // R05 R02
      end
      else if (nib == `ECSM_NIB_PRESC)
      begin
         // Divide by 2^M pulses whenever the low M counter bits are all ones.
         hit = &(presc | ~pmask); // R06
      end
      else if (nib >= `ECSM_NIB_TIMER_LO)
      begin
         if (sel[2:1] == `ECSM_TTYPE_RSV)
         begin
            hit = 1'b0; // R08 R21
         end
         else if (sel[3] && sel[2:1] == `ECSM_TTYPE_CD)
         begin
            hit = 1'b0; // R09 R21
         end
         else
         begin
            hit = TIMER_PRESENT[sel[5:3]] & tev[sel[5:0]]; // R07 R08 R09 R02
         end
      end
      // Zero and every reserved code fall through with no event.
      return hit; // R01 R21
   endfunction

   function automatic ecsm_step_type quadrature_decoder_step
   (
      input logic [1:0] prev,
      input logic [1:0] cur
   );
      logic [3:0] pair;
      pair = {prev, cur};
      case (pair)
         4'h1, 4'h7, 4'hE, 4'h8: quadrature_decoder_step = STEP_UP;
         4'h2, 4'hB, 4'hD, 4'h4: quadrature_decoder_step = STEP_DOWN;
         default:                quadrature_decoder_step = STEP_NONE;
      endcase
   endfunction

   for (genvar g = 0; g < `ECSM_NUM_CH; g++)
   begin : g_chan
      assign raw_event[g] = source_event(s_reg.channel_source_select[g], link.port_pin_source,
                                         link.misc_events, link.timer_events, s_reg.presc);
      ecsm_filter u_filter
      (
         .clock         (clock),
         .rst           (rst),
         .filter_length (s_reg.control[g][`ECSM_CTRL_FILT_MSB:`ECSM_CTRL_FILT_LSB]), // R20
         .sample        (raw_event[g]),
         .level         (filt_level[g])
      );
   end

   // Phase B is the pin right above phase A on the same port, with pin 7 wrapping round to pin 0.
   assign phase_b_raw = source_event({s_reg.channel_source_select[0][7:3],
                                      3'(s_reg.channel_source_select[0][2:0] + 3'h1)},
                                     link.port_pin_source, link.misc_events,
                                     link.timer_events, s_reg.presc);

   ecsm_filter u_phase_b_filter
   (
      .clock         (clock),
      .rst           (rst),
      .filter_length (s_reg.control[0][`ECSM_CTRL_FILT_MSB:`ECSM_CTRL_FILT_LSB]),
      .sample        (phase_b_raw),
      .level         (phase_b_level)
   );

   always_comb
   begin
      logic          decode_enable_bit;
      logic          index_enable_bit;
      logic [1:0]    index_match_state;
      logic [1:0]    cur_phase;
      logic          strobe_wr;
      logic          stb;
      logic          dat;
      ecsm_step_type quadrature_decoder_event;
      decode_enable_bit = s_reg.control[0][`ECSM_CTRL_DEN_BIT];
      index_enable_bit = s_reg.control[1][`ECSM_CTRL_IEN_BIT];
      index_match_state = s_reg.control[1][`ECSM_CTRL_IRM_MSB:`ECSM_CTRL_IRM_LSB];
      cur_phase = {filt_level[0], phase_b_level};
      strobe_wr = link.reg_wr && link.reg_addr == `ECSM_OFS_STROBE;
      stb = 1'b0;
      dat = 1'b0;
      quadrature_decoder_event = STEP_NONE;
      s_next = s_reg;
      s_next.presc = s_reg.presc + 16'h0001;
      s_next.phase = cur_phase;
      s_next.rdata = 8'h00;

      // A step wins over an index in the same cycle; the index is a level pulse.
      quadrature_decoder_event = quadrature_decoder_step(s_reg.phase, cur_phase); // R18 R15
      if (quadrature_decoder_event == STEP_NONE && index_enable_bit && filt_level[1]
          && cur_phase == index_match_state)
      begin
         quadrature_decoder_event = STEP_INDEX; // R19 R12
      end

      for (int i = 0; i < `ECSM_NUM_CH; i++)
      begin
         stb = filt_level[i];
         dat = 1'b0;
         if (i == 0 && decode_enable_bit)
         begin
            {stb, dat} = quadrature_decoder_event; // R18
         end
         if (strobe_wr && (link.reg_wdata[i] | s_reg.sw_data[i]))
         begin
            stb = link.reg_wdata[i]; // R03
            dat = s_reg.sw_data[i]; // R03
         end
         s_next.chan_strobe[i] = stb;
         s_next.chan_data[i] = dat;
      end

      if (link.reg_wr)
      begin
         for (int i = 0; i < `ECSM_NUM_CH; i++)
         begin
            if (link.reg_addr == `ECSM_OFS_MUX_BASE + 8'(i))
            begin
               s_next.channel_source_select[i] = link.reg_wdata; // R22
            end
            if (link.reg_addr == `ECSM_OFS_CTRL_BASE + 8'(i))
            begin
               s_next.control[i] = link.reg_wdata & `ECSM_CTRL_WMASK;
            end
         end
         if (link.reg_addr == `ECSM_OFS_DATA)
         begin
            s_next.sw_data = link.reg_wdata[3:0];
         end
      end

      if (link.reg_rd)
      begin
         for (int i = 0; i < `ECSM_NUM_CH; i++)
         begin
            if (link.reg_addr == `ECSM_OFS_MUX_BASE + 8'(i))
            begin
               s_next.rdata = s_reg.channel_source_select[i]; // R22
            end
            if (link.reg_addr == `ECSM_OFS_CTRL_BASE + 8'(i))
            begin
               s_next.rdata = s_reg.control[i];
            end
         end
         if (link.reg_addr == `ECSM_OFS_DATA)
         begin
            s_next.rdata = {4'h0, s_reg.sw_data};
         end
         if (link.reg_addr == `ECSM_OFS_STATUS)
         begin
            s_next.rdata = {2'h0, s_reg.phase, filt_level};
         end
      end
   end

   always_ff @(posedge clock)
   begin
      if (rst)
      begin
         s_reg <= '0; // R22
      end
      else
      begin
         s_reg <= s_next;
      end
   end

   assign link.reg_rdata = s_reg.rdata;
   assign link.chan_strobe = s_reg.chan_strobe;
   assign link.chan_data = s_reg.chan_data;
endmodule

/* ecsm_timer.sv */
// Generator and timer end: drives event sources and counts quadrature steps.
`timescale 1ns/100ps
`include "ecsm_map.svh"
module ecsm_timer
(
   input  wire logic        clock,
   input  wire logic        rst,
   input  wire logic [7:0]  addr,
   input  wire logic [15:0] wr_data,
   input  wire logic        wr_stb,
   input  wire logic        rd_stb,
   output logic      [15:0] rd_data,
   input  wire logic [47:0] pin_in,
   input  wire logic [5:0]  misc_in,
   ecsm_link_if.gen         link
);
   import ecsm_pkg::*;

   ecsm_host_state_type s_reg;
   ecsm_host_state_type s_next;
   logic                dev_space;

   assign dev_space = addr < `ECSM_OFS_HOST_BASE;
   assign link.reg_addr = addr;
   assign link.reg_wdata = wr_data[7:0];
   assign link.reg_wr = wr_stb && dev_space;
   assign link.reg_rd = rd_stb && dev_space;

   always_comb
   begin
      logic [1:0] ch;
      logic       stb;
      logic       dat;
      logic       up;
      logic       down;
      logic       index;
      logic       set_err;
      ch = s_reg.ctrl[`ECSM_TC_CH_MSB:`ECSM_TC_CH_LSB];
      stb = link.chan_strobe[ch]; // R13
      dat = link.chan_data[ch];
      up = 1'b0;
      down = 1'b0;
      index = 1'b0;
      set_err = 1'b0;
      s_next = s_reg;
      s_next.pins = pin_in;
      s_next.misc = misc_in;
      s_next.tev_wrap = 1'b0;
      s_next.dev_rd = rd_stb && dev_space;
      s_next.rdata = 16'h0000;

      if (s_reg.ctrl[`ECSM_TC_EN_BIT])
      begin
         if (s_reg.ctrl[`ECSM_TC_QUADRATURE_DECODER_BIT])
         begin
            up = stb & dat; // R15
            down = stb & ~dat; // R15
            index = ~stb & dat;
         end
         else
         begin
            up = stb;
         end
      end

      if ((up || down) && s_reg.count == 16'h0000)
      begin
         // Leaving count_floor without an index since the last departure is a lost index.
         set_err = s_reg.ctrl[`ECSM_TC_IDX_BIT] && !s_reg.idx_seen; // R17
         s_next.idx_seen = 1'b0;
      end
      if (up)
      begin
         s_next.tev_wrap = s_reg.count == s_reg.period; // R14
         s_next.count = s_next.tev_wrap ? 16'h0000 : s_reg.count + 16'h0001;
      end
      else if (down)
      begin
         s_next.tev_wrap = s_reg.count == 16'h0000; // R14
         s_next.count = s_next.tev_wrap ? s_reg.period : s_reg.count - 16'h0001;
      end
      else if (index)
      begin
         set_err = s_reg.count != 16'h0000; // R16
         s_next.count = 16'h0000;
         s_next.idx_seen = 1'b1;
      end

      if (wr_stb)
      begin
         if (addr == `ECSM_OFS_TCTRL)
         begin
            s_next.ctrl = wr_data[`ECSM_TC_CTRL_WIDTH-1:0];
         end
         if (addr == `ECSM_OFS_PERIOD)
         begin
            s_next.period = wr_data;
         end
         if (addr == `ECSM_OFS_COUNT)
         begin
            s_next.count = wr_data;
         end
         if (addr == `ECSM_OFS_TSTAT && wr_data[`ECSM_TSTAT_ERR_BIT])
         begin
            s_next.err = 1'b0;
         end
      end
      // A new error in the clearing cycle is kept.
      if (set_err)
      begin
         s_next.err = 1'b1; // R16 R17
      end
      s_next.tev_err = set_err;

      if (rd_stb)
      begin
         if (addr == `ECSM_OFS_TCTRL)
         begin
            s_next.rdata = 16'(s_reg.ctrl);
         end
         if (addr == `ECSM_OFS_PERIOD)
         begin
            s_next.rdata = s_reg.period;
         end
         if (addr == `ECSM_OFS_COUNT)
         begin
            s_next.rdata = s_reg.count; // R15
         end
         if (addr == `ECSM_OFS_TSTAT)
         begin
            s_next.rdata = {15'h0000, s_reg.err};
         end
      end
   end

   always_ff @(posedge clock)
   begin
      if (rst)
      begin
         s_reg <= '0;
         s_reg.period <= `ECSM_PERIOD_RESET;
         s_reg.idx_seen <= 1'b1;
      end
      else
      begin
         s_reg <= s_next;
      end
   end

   // Router reads are answered by its own register, so only the final mux is shared.
   assign rd_data = s_reg.dev_rd ? {8'h00, link.reg_rdata} : s_reg.rdata;
   assign link.port_pin_source = s_reg.pins;
   assign link.misc_events = s_reg.misc;
   assign link.timer_events = {62'h0, s_reg.tev_err, s_reg.tev_wrap};
endmodule

/* ecsm_checker.sv */
// Concurrent checks on the link between the event router and the timer end.
`timescale 1ns/100ps
module ecsm_checker
#(
   parameter logic [5:0] MISC_PRESENT = 6'h3F
)
(
   input wire logic        clock,
   input wire logic        rst,
   input wire logic [7:0]  reg_addr,
   input wire logic [7:0]  reg_wdata,
   input wire logic        reg_wr,
   input wire logic        reg_rd,
   input wire logic [7:0]  reg_rdata,
   input wire logic [47:0] port_pin_source,
   input wire logic [5:0]  misc_events,
   input wire logic [63:0] timer_events,
   input wire logic [3:0]  chan_strobe,
   input wire logic [3:0]  chan_data
);
   logic [7:0] sel_reg [4];
   logic [7:0] s3;
   logic [2:0] filt_reg;
   logic [3:0] data_reg;
   logic [7:0] exp_reg;
   logic [3:0] quiet_reg;
   logic [3:0] run_reg;
   logic       sw_reg;
   logic       src;
   logic       rsv;
   logic       presc;
   logic [2:0] mi;

   assign s3 = sel_reg[3];

   // Expected raw source of channel 3; the prescaler is left to the bench.
   always_comb
   begin
      presc = s3[7:4] == 4'h8;
      src   = 1'b0;
      rsv   = 1'b0;
      case (s3)
         8'h08: mi = 3'h0;
         8'h09: mi = 3'h1;
         8'h10: mi = 3'h2;
         8'h11: mi = 3'h3;
         8'h12: mi = 3'h4;
         8'h20: mi = 3'h5;
         default: mi = 3'h7;
      endcase
      if (s3[7:4] >= 4'h5 && s3[7:4] <= 4'h7)
         src = port_pin_source[{s3[5:4] - 2'h1, s3[3:0]}];
      else if (s3[7:6] == 2'b11)
      begin
         rsv = s3[2:1] == 2'b01 || (s3[3] && s3[2:1] == 2'b11);
         src = timer_events[s3[5:0]];
      end
      else if (mi != 3'h7)
      begin
         src = misc_events[mi];
         rsv = !MISC_PRESENT[mi];
      end
      else
         rsv = !presc;
   end

   // The settle count hides the filter pipeline after a selector or filter change.
   always_ff @(posedge clock)
   begin
      exp_reg <= sel_reg[reg_addr[1:0]];
      sw_reg  <= reg_wr && reg_addr == 8'h10 && (reg_wdata[3] || data_reg[3]);
      run_reg <= src ? run_reg + {3'h0, run_reg != 4'hF} : 4'h0;
      if (rst || (reg_wr && (reg_addr == 8'h03 || reg_addr == 8'h0B)))
         quiet_reg <= 4'h0;
      else if (quiet_reg != 4'hF)
         quiet_reg <= quiet_reg + 4'h1;
      if (rst)
      begin
         sel_reg  <= '{default: 8'h00};
         filt_reg <= 3'h0;
         data_reg <= 4'h0;
      end
      else if (reg_wr && reg_addr < 8'h04)
         sel_reg[reg_addr[1:0]] <= reg_wdata;
      else if (reg_wr && reg_addr == 8'h0B)
         filt_reg <= reg_wdata[2:0];
      else if (reg_wr && reg_addr == 8'h11)
         data_reg <= reg_wdata[3:0];
   end

   default clocking cb @(posedge clock);
   endclocking
   default disable iff (rst);

   sequence s_sw_write;
      reg_wr && reg_addr == 8'h10;
   endsequence

   sequence s_ch3_settled;
      quiet_reg >= 4'hC && !sw_reg && !presc;
   endsequence

   a_sw_strobe:
      assert property (s_sw_write |=> (chan_strobe & $past(reg_wdata[3:0])) == $past(reg_wdata[3:0]))
      else $error("software strobe missing");
   a_sw_data:
      assert property (s_sw_write |=> ((chan_data ^ data_reg) & $past(reg_wdata[3:0])) == 4'h0)
      else $error("software data bit wrong");
   a_rd_idle:
      assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
      else $error("read data outside read slot");
   a_sel_read:
      assert property (reg_rd && reg_addr < 8'h04 |=> reg_rdata == exp_reg)
      else $error("selector read back wrong");
   a_reset_clear:
      assert property ($fell(rst) |-> chan_strobe == 4'h0 && reg_rdata == 8'h00)
      else $error("outputs not cleared by reset");
   a_zero_quiet:
      assert property (s_ch3_settled ##0 rsv |-> !chan_strobe[3])
      else $error("event on channel with no source");
   a_route_ch3:
      assert property (s_ch3_settled ##0 (filt_reg == 3'h0 && !rsv) |-> chan_strobe[3] == $past(src, 2))
      else $error("routed source differs");
   a_filter_run:
      assert property (s_ch3_settled ##0 $rose(chan_strobe[3]) |-> $past(run_reg) > {1'b0, filt_reg})
      else $error("filter passed a short level");
endmodule

/* tb.sv */
// Self-checking bench for the event router joined to the timer end.
`timescale 1ns/100ps
module tb;
   logic        clock;
   logic        rst;
   logic [7:0]  addr;
   logic [15:0] wr_data;
   logic        wr_stb;
   logic        rd_stb;
   logic [15:0] rd_data;
   logic [47:0] pin_in;
   logic [5:0]  misc_in;
   int          err_total;
   int          samples_checked;
   int          c;
   // Code, stimulus line (30 up are misc, 3E none, 3F all) and strobe count over 48 cycles.
   localparam logic [23:0] TAB [16] = '{24'h083030, 24'h093130, 24'h103230, 24'h113330,
      24'h123430, 24'h203500, 24'h5B0B30, 24'h6A1A30, 24'h7F2F30, 24'h803E30, 24'h833E06,
      24'h843E03, 24'h013F00, 24'h303F00, 24'hC23F00, 24'h003F00};
   localparam logic [2:0] UP [4] = '{3'b010, 3'b011, 3'b001, 3'b000};

   ecsm_link_if link ();
   // The converter is left absent so that an absent source can be seen to fall silent.
   ecsm_router #(.MISC_PRESENT(6'h1F)) ecsm_router_i (.clock(clock), .rst(rst), .link(link));
   ecsm_timer ecsm_timer_i (.clock(clock), .rst(rst), .addr(addr), .wr_data(wr_data),
      .wr_stb(wr_stb), .rd_stb(rd_stb), .rd_data(rd_data), .pin_in(pin_in),
      .misc_in(misc_in), .link(link));
   ecsm_checker #(.MISC_PRESENT(6'h1F)) ecsm_checker_i (.clock(clock), .rst(rst),
      .reg_addr(link.reg_addr), .reg_wdata(link.reg_wdata), .reg_wr(link.reg_wr),
      .reg_rd(link.reg_rd), .reg_rdata(link.reg_rdata), .port_pin_source(link.port_pin_source),
      .misc_events(link.misc_events), .timer_events(link.timer_events),
      .chan_strobe(link.chan_strobe), .chan_data(link.chan_data));

   task automatic report_and_stop;
      $display("checks %0d errors %0d", samples_checked, err_total);
      if (err_total == 0 && samples_checked > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
      samples_checked++;
      if (g !== e)
      begin
         err_total++;
         $display("CHECK FAILED %s expected %h seen %h", n, e, g);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      @(posedge clock);
      addr    <= a;
      wr_data <= d;
      wr_stb  <= 1'b1;
      @(posedge clock);
      wr_stb  <= 1'b0;
   endtask

   task automatic rdc(input logic [7:0] a, input logic [15:0] e);
      @(posedge clock);
      addr   <= a;
      rd_stb <= 1'b1;
      @(posedge clock);
      rd_stb <= 1'b0;
      #1;
      chk($sformatf("reg %h", a), e, rd_data);
   endtask

   task automatic step(input logic [2:0] v);
      @(posedge clock);
      pin_in <= {45'h0, v};
      repeat (6) @(posedge clock);
   endtask

   // Holds the sources for n of 48 cycles and counts strobes on channel 3.
   task automatic run3(input int n, input logic [47:0] p, input logic [5:0] m, output int k);
      k = 0;
      for (int i = 0; i < 48; i++)
      begin
         @(posedge clock);
         pin_in  <= (i < n) ? p : '0;
         misc_in <= (i < n) ? m : '0;
         #1;
         if (link.chan_strobe[3] !== 1'b0)
            k++;
      end
   endtask

   task automatic t_reset;
      for (int i = 0; i < 5; i++)
         rdc(8'(i), 16'h0000);
   endtask

   task automatic t_rw;
      for (int i = 0; i < 4; i++)
         wr(8'(i), 16'h00A5 ^ 16'(i << 4));
      wr(8'h30, 16'h00FF);
      for (int i = 0; i < 4; i++)
         rdc(8'(i), 16'h00A5 ^ 16'(i << 4));
      rdc(8'h30, 16'h0000);
   endtask

   task automatic t_codes;
      logic [5:0]  s;
      logic [47:0] p;
      logic [5:0]  m;
      for (int i = 0; i < 16; i++)
      begin
         s = TAB[i][13:8];
         p = (s == 6'h3F) ? '1 : (s < 6'h30) ? 48'h1 << s : '0;
         m = (s == 6'h3F) ? '1 : (s < 6'h36 && s >= 6'h30) ? 6'h1 << (s - 6'h30) : '0;
         wr(8'h03, {8'h00, TAB[i][23:16]});
         run3(48, p, m, c);
         run3(48, p, m, c);
         chk($sformatf("count %h", TAB[i][23:16]), {8'h00, TAB[i][7:0]}, c[15:0]);
      end
   endtask

   task automatic t_sw;
      wr(8'h03, 16'h0000);
      pin_in <= '1;
      wr(8'h11, 16'h0009);
      wr(8'h10, 16'h000F);
      #1;
      chk("strobe", 16'h000F, {12'h0, link.chan_strobe});
      chk("data", 16'h0009, {12'h0, link.chan_data});
      @(posedge clock);
      #1;
      chk("idle channel", 16'h0000, {15'h0, link.chan_strobe[3]});
   endtask

   task automatic t_quad;
      step(3'b000);
      wr(8'h00, 16'h0050);
      wr(8'h08, 16'h0008);
      wr(8'h03, 16'h00C0);
      wr(8'h21, 16'h0007);
      wr(8'h20, 16'h0003);
      for (int i = 0; i < 8; i++)
      begin
         step(UP[i % 4]);
         if (i == 2)
            rdc(8'h22, 16'h0003);
      end
      rdc(8'h22, 16'h0000);
      step(3'b001);
      rdc(8'h22, 16'h0007);
   endtask

   task automatic t_index;
      wr(8'h01, 16'h0052);
      wr(8'h09, 16'h0050);
      wr(8'h20, 16'h0007);
      wr(8'h03, 16'h00C1);
      step(3'b101);
      rdc(8'h23, 16'h0001);
      rdc(8'h22, 16'h0000);
      step(3'b001);
      wr(8'h23, 16'h0001);
      rdc(8'h23, 16'h0000);
      step(3'b011);
      rdc(8'h23, 16'h0000);
      step(3'b001);
      step(3'b000);
      rdc(8'h23, 16'h0001);
      step(3'b100);
      rdc(8'h22, 16'h0001);
   endtask

   task automatic t_filter;
      wr(8'h03, 16'h0050);
      wr(8'h0B, 16'h0003);
      wr(8'h20, 16'h0019);
      wr(8'h22, 16'h0000);
      run3(0, 48'h0, 6'h0, c);
      run3(3, 48'h1, 6'h0, c);
      chk("short pulse", 16'h0000, c[15:0]);
      run3(4, 48'h1, 6'h0, c);
      chk("long pulse", 16'h0004, c[15:0]);
      rdc(8'h22, 16'h0004);
   endtask

   initial
   begin
      clock = 1'b0;
      forever #2.5 clock = ~clock;
   end

   initial
   begin
      repeat (10000) @(posedge clock);
      err_total++;
      report_and_stop;
   end

   initial
   begin
      rst = 1'b1;
      addr = 8'h00;
      wr_data = 16'h0000;
      wr_stb = 1'b0;
      rd_stb = 1'b0;
      pin_in = 48'h0;
      misc_in = 6'h00;
      err_total = 0;
      samples_checked = 0;
      repeat (4) @(posedge clock);
      rst <= 1'b0;
      t_reset;
      t_rw;
      t_codes;
      t_sw;
      t_quad;
      t_index;
      t_filter;
      report_and_stop;
   end
endmodule
